// ==== seek_pkg.sv ====
// constants, register map and state type for the seek and step logic
// assumes a 125 MHz core clock and a 32-bit AHB-Lite register port
package seek_pkg;
    localparam int CLK_NS       = 8;
    localparam int QUIET_NS     = 13000;
    localparam int QUIET_CYC    = (QUIET_NS + CLK_NS - 1) / CLK_NS;
    localparam int LEAD_NS      = 11000;
    localparam int LEAD_CYC     = LEAD_NS / CLK_NS;
    localparam int SETTLE_NS    = 5000000;
    localparam int SETTLE_CYC   = SETTLE_NS / CLK_NS;
    localparam int MOVE_NS      = 25000;
    localparam int MOVE_CYC     = MOVE_NS / CLK_NS;
    localparam int TMR_W        = 20;
    localparam int LAST_CYL     = 917;
    localparam int PEND_MAX     = 917;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_POS  = 12'h008;
    localparam logic [11:0] OFS_PEND = 12'h00C;
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam int STAT_READY   = 0;
    localparam int STAT_SETTLED = 1;
    localparam int STAT_CYL0    = 2;
    localparam int STAT_ERR     = 3;
    localparam int STAT_BUSY    = 4;
    localparam int STAT_UNLOCK  = 5;
    typedef enum {ST_LOCKED, ST_RECAL, ST_IDLE, ST_MOVE, ST_SETTLE}
        seek_state_t;
endpackage : seek_pkg

// ==== seek_reg_if.sv ====
// carrier between the register slave and the seek core
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface seek_reg_if;
    logic [1:0]  unit;
    logic [31:0] stat;
    logic [31:0] pos;
    logic [31:0] pend;
    modport slave (output unit, input stat, input pos, input pend);
    modport core  (input unit, output stat, output pos, output pend);
endinterface : seek_reg_if

// ==== cycle_timer.sv ====
// one-shot down counter: busy while running, done pulse at expiry
// assumes a synchronous start request; restart reloads the count
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W     = 20,
    parameter int COUNT = 1
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);
    logic [W-1:0] cnt_reg;

    if (COUNT < 1 || COUNT >= 2 ** W)
    begin : g_bad
        $error("cycle_timer count out of range");
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_reg <= '0;
        else if (i_start)
            cnt_reg <= COUNT[W-1:0];
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_done <= 1'b0;
        else
            o_done <= (cnt_reg == 1) && !i_start;
    end

    assign o_busy = (cnt_reg != '0);

    chk_timer_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_start |=> cnt_reg == COUNT[W-1:0])
        else $error("timer did not load its count");
endmodule : cycle_timer

// ==== seek_ahb_slave.sv ====
// AHB-Lite slave for the seek core registers, zero wait states
// assumes single word transfers; other sizes write nothing
`timescale 1ns/1ps
module seek_ahb_slave (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    seek_reg_if.slave        regs
);
    logic        wr_reg;
    logic [11:0] wa_reg;
    logic        take;

    assign take = i_hsel && i_hready && i_htrans[1];

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_reg <= 1'b0;
            wa_reg <= 12'h000;
        end
        else
        begin
            wr_reg <= take && i_hwrite && (i_hsize == 3'h2);
            wa_reg <= i_haddr[11:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            regs.unit <= seek_pkg::CTRL_RST;
        else if (wr_reg && wa_reg == seek_pkg::OFS_CTRL)
            regs.unit <= i_hwdata[1:0];
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_hrdata <= 32'h0;
        else if (take && !i_hwrite)
            unique case (i_haddr[11:0])
                seek_pkg::OFS_CTRL: o_hrdata <= {30'h0, regs.unit};
                seek_pkg::OFS_STAT: o_hrdata <= regs.stat;
                seek_pkg::OFS_POS:  o_hrdata <= regs.pos;
                seek_pkg::OFS_PEND: o_hrdata <= regs.pend;
                default:            o_hrdata <= 32'h0;
            endcase
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
endmodule : seek_ahb_slave

// ==== seek_step_drive_interface.sv ====
// seek and step control core of the drive: power-up recalibration,
// unit gating, buffered step capture, head stepping and status lines
// assumes host lines are synchronous to i_clk and active low
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module seek_step_drive_interface #(
    parameter int SETTLE_CYC = seek_pkg::SETTLE_CYC,
    parameter int MOVE_CYC   = seek_pkg::MOVE_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic [3:0]  i_unit_sel_n,
    input  wire logic        i_rec_en_n,
    input  wire logic [3:0]  i_head_addr_n,
    input  wire logic        i_heading_n,
    input  wire logic        i_pulse_n,
    output logic      [3:0]  o_stat_n,
    output logic      [3:0]  o_stat_oe,
    input  wire logic        i_spindle_locked,
    input  wire logic        i_at_outer,
    input  wire logic        i_fault_cond,
    output logic             o_lock_release,
    output logic             o_move_step,
    output logic             o_move_out,
    output logic      [3:0]  o_head_sel,
    output logic             o_write_en
);
    seek_pkg::seek_state_t state_reg, state_next;
    seek_reg_if            regs ();

    logic               pulse_prev_reg;
    logic               ready_reg;
    logic               settled_reg;
    logic               err_reg;
    logic [9:0]         cyl_reg;
    logic [9:0]         target_reg;
    logic signed [10:0] pend_reg, pend_next;
    logic               sel, ok, fall, rise, seek_start;
    logic               quiet_busy, lead_done, move_done, settle_done;
    logic               move_start, settle_start, step_now;
    logic signed [11:0] sum;
    logic [9:0]         target_next;

    if (SETTLE_CYC < 1 || MOVE_CYC < 1)
    begin : g_bad
        $error("timing counts must be at least one cycle");
    end

    seek_ahb_slave u_ahb (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_hsel      (i_hsel),
        .i_haddr     (i_haddr),
        .i_htrans    (i_htrans),
        .i_hwrite    (i_hwrite),
        .i_hsize     (i_hsize),
        .i_hwdata    (i_hwdata),
        .i_hready    (i_hready),
        .o_hrdata    (o_hrdata),
        .o_hreadyout (o_hreadyout),
        .o_hresp     (o_hresp),
        .regs        (regs.slave)
    );

    // unit number from the control register picks our select line
    assign sel  = !i_unit_sel_n[regs.unit];
    assign ok   = sel && ready_reg && !err_reg;
    assign fall = pulse_prev_reg && !i_pulse_n;
    assign rise = !pulse_prev_reg && i_pulse_n;

    assign seek_start = (state_reg == seek_pkg::ST_IDLE)
                        && (pend_reg != 0) && !quiet_busy;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pulse_prev_reg <= 1'b1;
        else
            pulse_prev_reg <= i_pulse_n;
    end

    // restarts on every trailing edge taken while ok; expiry closes the buffered batch
    cycle_timer #(.W(seek_pkg::TMR_W), .COUNT(seek_pkg::QUIET_CYC))
    u_quiet (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (rise && ok),
        .o_busy  (quiet_busy),
        .o_done  ()
    );

    cycle_timer #(.W(seek_pkg::TMR_W), .COUNT(seek_pkg::LEAD_CYC))
    u_lead (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (fall && ok),
        .o_busy  (),
        .o_done  (lead_done)
    );

    cycle_timer #(.W(seek_pkg::TMR_W), .COUNT(MOVE_CYC))
    u_move (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (move_start),
        .o_busy  (),
        .o_done  (move_done)
    );

    cycle_timer #(.W(seek_pkg::TMR_W), .COUNT(SETTLE_CYC))
    u_settle (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (settle_start),
        .o_busy  (),
        .o_done  (settle_done)
    );

    // pulse buffer: heading low steps inward (+1), high outward (-1)
    always_comb
    begin
        pend_next = seek_start ? 11'sd0 : pend_reg;
        if (rise && ok)
        begin
            if (!i_heading_n && pend_next < seek_pkg::PEND_MAX)
                pend_next = pend_next + 11'sd1;
            else if (i_heading_n && pend_next > -seek_pkg::PEND_MAX)
                pend_next = pend_next - 11'sd1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pend_reg <= 11'sd0;
        else
            pend_reg <= pend_next;
    end

    // destination clamped to the cylinder range
    always_comb
    begin
        sum = $signed({2'b00, cyl_reg}) + 12'(pend_reg);
        if (sum < 0)
            target_next = 10'h000;
        else if (sum > seek_pkg::LAST_CYL)
            target_next = 10'(seek_pkg::LAST_CYL);
        else
            target_next = sum[9:0];
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            target_reg <= 10'h000;
        else if (seek_start)
            target_reg <= target_next;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            seek_pkg::ST_LOCKED:
                if (i_spindle_locked)
                    state_next = seek_pkg::ST_RECAL;
            seek_pkg::ST_RECAL:
                if (move_done && i_at_outer)
                    state_next = seek_pkg::ST_SETTLE;
            seek_pkg::ST_IDLE:
                if (seek_start)
                    state_next = (target_next == cyl_reg)
                                 ? seek_pkg::ST_SETTLE
                                 : seek_pkg::ST_MOVE;
            seek_pkg::ST_MOVE:
                if (cyl_reg == target_reg)
                    state_next = seek_pkg::ST_SETTLE;
            seek_pkg::ST_SETTLE:
                if (settle_done)
                    state_next = seek_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_reg <= seek_pkg::ST_LOCKED;
        else
            state_reg <= state_next;
    end

    assign move_start = (state_next == seek_pkg::ST_RECAL
                         || state_next == seek_pkg::ST_MOVE)
                        && (state_next != state_reg || move_done);
    assign settle_start = (state_next == seek_pkg::ST_SETTLE)
                          && (state_reg != seek_pkg::ST_SETTLE);
    assign step_now = move_done && !err_reg
        && ((state_reg == seek_pkg::ST_RECAL && !i_at_outer)
            || (state_reg == seek_pkg::ST_MOVE && cyl_reg != target_reg));

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cyl_reg <= 10'h000;
        else if (state_reg == seek_pkg::ST_RECAL && move_done && i_at_outer)
            cyl_reg <= 10'h000;
        else if (step_now && state_reg == seek_pkg::ST_MOVE)
            cyl_reg <= (target_reg > cyl_reg) ? cyl_reg + 10'h001
                                               : cyl_reg - 10'h001;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_move_step <= 1'b0;
            o_move_out  <= 1'b0;
        end
        else
        begin
            o_move_step <= step_now;
            if (step_now)
                o_move_out <= (state_reg == seek_pkg::ST_RECAL)
                              || (target_reg < cyl_reg);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_lock_release <= 1'b0;
        else if (state_reg == seek_pkg::ST_LOCKED && i_spindle_locked)
            o_lock_release <= 1'b1;
    end

    // ready and settled rise on the same edge at the end of recal
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ready_reg <= 1'b0;
        else if (settle_done)
            ready_reg <= 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            settled_reg <= 1'b0;
        else if (lead_done)
            settled_reg <= 1'b0;
        else if (settle_done && pend_reg == 0)
            settled_reg <= 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            err_reg <= 1'b0;
        else
            err_reg <= i_fault_cond;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_head_sel <= 4'h0;
            o_write_en <= 1'b0;
        end
        else
        begin
            if (sel)
                o_head_sel <= ~i_head_addr_n;
            o_write_en <= ok && !i_rec_en_n;
        end
    end

    // open-drain status: line pulled low only by the selected unit
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_stat_oe <= 4'h0;
        else
            o_stat_oe <= sel ? {err_reg, ready_reg && cyl_reg == 0,
                                settled_reg, ready_reg}
                             : 4'h0;
    end

    assign o_stat_n = 4'h0;

    assign regs.stat = {26'h0, o_lock_release,
                        state_reg != seek_pkg::ST_IDLE, err_reg,
                        ready_reg && cyl_reg == 0, settled_reg, ready_reg};
    assign regs.pos  = {22'h0, cyl_reg};
    assign regs.pend = 32'(pend_reg);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    chk_unlock_spinup: assert property (
        state_reg == seek_pkg::ST_LOCKED && i_spindle_locked
        |=> o_lock_release && state_reg == seek_pkg::ST_RECAL)
        else $error("actuator not released after spin-up");
    chk_status_together: assert property (
        $rose(ready_reg) |-> settled_reg && cyl_reg == 0)
        else $error("ready rose without settled at cylinder zero");
    chk_refuse_unready: assert property (
        !ready_reg |-> pend_reg == 0 && !o_write_en && !o_move_step
                       || state_reg == seek_pkg::ST_RECAL)
        else $error("activity while not ready");
    chk_unselected_quiet: assert property (
        !sel |=> o_stat_oe == 4'h0)
        else $error("unselected unit drives status");
    chk_one_track: assert property (
        o_move_step && ready_reg
        |-> cyl_reg == $past(cyl_reg) + 10'h001
            || cyl_reg + 10'h001 == $past(cyl_reg))
        else $error("step moved other than one track");
    chk_heading_sense: assert property (
        o_move_step && ready_reg |-> o_move_out == (cyl_reg < $past(cyl_reg)))
        else $error("step direction wrong");
    chk_batch_start: assert property (
        seek_start && target_next != cyl_reg
        |=> state_reg == seek_pkg::ST_MOVE ##1 pend_reg != $past(pend_reg, 2)
            || pend_reg == 0)
        else $error("buffered batch not started");
    chk_cyl_range: assert property (
        cyl_reg <= seek_pkg::LAST_CYL && target_reg <= seek_pkg::LAST_CYL)
        else $error("cylinder out of range");
    chk_trailing_only: assert property (
        !rise && !seek_start |=> $stable(pend_reg))
        else $error("buffer changed without trailing edge");
    chk_buffer_limit: assert property (
        pend_reg <= seek_pkg::PEND_MAX && pend_reg >= -seek_pkg::PEND_MAX)
        else $error("buffer beyond limit");
    chk_settle_drop: assert property (
        lead_done |=> !settled_reg [*2])
        else $error("settled not dropped after leading edge");
    chk_fault_block: assert property (
        err_reg |=> !o_write_en && !o_move_step)
        else $error("write or step during recording error");

    cov_recal_done: cover property ($rose(ready_reg));
    cov_seek_done: cover property (
        state_reg == seek_pkg::ST_MOVE ##[1:1000] $rose(settled_reg));
    cov_fault_hold: cover property (err_reg && state_reg == seek_pkg::ST_MOVE);
endmodule : seek_step_drive_interface

// ==== seek_host_model.sv ====
// host controller model driving the drive's control lines
// assumes the bench calls its tasks; all lines are active low
`timescale 1ns/1ps
module seek_host_model (
    input  wire logic       i_clk,
    output logic      [3:0] o_unit_sel_n,
    output logic            o_rec_en_n,
    output logic      [3:0] o_head_addr_n,
    output logic            o_heading_n,
    output logic            o_pulse_n
);
    initial
    begin
        o_unit_sel_n  = 4'hF;
        o_rec_en_n    = 1'b1;
        o_head_addr_n = 4'hF;
        o_heading_n   = 1'b1;
        o_pulse_n     = 1'b1;
    end

    task automatic select(input logic [3:0] lines);
        @(posedge i_clk);
        o_rec_en_n   <= 1'b1;
        o_unit_sel_n <= ~lines;
    endtask : select

    task automatic press;
        @(posedge i_clk);
        o_pulse_n <= 1'b0;
        @(posedge i_clk);
    endtask : press

    task automatic lift;
        @(posedge i_clk);
        o_pulse_n <= 1'b1;
        @(posedge i_clk);
    endtask : lift

    // heading set first, held over the whole burst
    task automatic step(input int n, input logic outward);
        @(posedge i_clk);
        o_heading_n <= outward;
        repeat (n)
        begin
            press();
            lift();
        end
    endtask : step

    task automatic head(input logic [3:0] h);
        @(posedge i_clk);
        o_head_addr_n <= ~h;
    endtask : head

    task automatic record(input logic en);
        @(posedge i_clk);
        o_rec_en_n <= ~en;
    endtask : record
endmodule : seek_host_model

// ==== seek_step_drive_interface_tb.sv ====
// self-checking bench for the seek and step core
// assumes the host model file and short move and settle counts
`timescale 1ns/1ps
module seek_step_drive_interface_tb;
    logic        i_clk;
    logic        i_rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic [3:0]  sel_n;
    logic        rec_n;
    logic [3:0]  head_n;
    logic        dir_n;
    logic        pulse_n;
    logic [3:0]  stat_oe;
    logic [3:0]  stat_n;
    logic        hresp;
    logic [2:0]  wsz;
    logic        spun;
    logic        outer;
    logic        fault;
    logic        unlock;
    logic        mstep;
    logic        mout;
    logic [3:0]  head_sel;
    logic        wr_en;
    logic [31:0] rd;
    int          n_errors;
    int          checks_done;
    int          n_in;
    int          n_out;

    seek_host_model host (.i_clk(i_clk), .o_unit_sel_n(sel_n),
        .o_rec_en_n(rec_n), .o_head_addr_n(head_n),
        .o_heading_n(dir_n), .o_pulse_n(pulse_n));

    seek_step_drive_interface #(.SETTLE_CYC(50), .MOVE_CYC(10)) i_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_unit_sel_n(sel_n), .i_rec_en_n(rec_n),
        .i_head_addr_n(head_n), .i_heading_n(dir_n),
        .i_pulse_n(pulse_n), .o_stat_n(stat_n), .o_stat_oe(stat_oe),
        .i_spindle_locked(spun), .i_at_outer(outer),
        .i_fault_cond(fault), .o_lock_release(unlock),
        .o_move_step(mstep), .o_move_out(mout),
        .o_head_sel(head_sel), .o_write_en(wr_en));

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        if (mstep === 1'b1)
        begin
            if (mout === 1'b1)
                n_out++;
            else
                n_in++;
        end
    end

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic give_up;
        n_errors++;
        $display("[ERR] %0t wait timed out", $time);
        finish_test();
    endtask : give_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_oe(input int idx, input logic val, input int lim);
        int k;
        k = 0;
        while (stat_oe[idx] !== val && k < lim)
        begin
            @(posedge i_clk);
            #1;
            k++;
        end
        if (k == lim)
            give_up();
    endtask : wait_oe

    task automatic wait_hready;
        int k;
        for (k = 0; k < 50; k++)
        begin
            @(posedge i_clk);
            if (hready === 1'b1)
                break;
        end
        if (k == 50)
            give_up();
    endtask : wait_hready

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= wsz;
        wait_hready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_hready();
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp,
                        input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rchk

    task automatic seek(input int n, input logic outward, input int pos);
        n_in = 0;
        n_out = 0;
        host.step(n, outward);
        chk(stat_oe[1], 1'b1, "settled early");
        rchk(seek_pkg::OFS_PEND, outward ? -n : n, "pending");
        wait_oe(1, 1'b0, 2000);
        wait_oe(1, 1'b1, 6000);
        chk(n_in, outward ? 0 : n, "inward steps");
        chk(n_out, outward ? n : 0, "outward steps");
        rchk(seek_pkg::OFS_POS, pos, "position");
        $display("test seek %0d done", n);
    endtask : seek

    initial
    begin
        int k;
        i_rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        wsz = 3'h2;
        hwdata = 32'h0;
        spun = 1'b0;
        outer = 1'b0;
        fault = 1'b0;
        n_errors = 0;
        checks_done = 0;
        n_in = 0;
        n_out = 0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        host.select(4'h1);
        host.step(2, 1'b0);
        rchk(seek_pkg::OFS_PEND, 32'h0, "pulse before ready");
        chk(unlock, 1'b0, "lock early");
        chk(stat_oe, 4'h0, "status early");
        $display("test before spin-up done");
        @(posedge i_clk);
        spun <= 1'b1;
        for (k = 0; k < 400 && n_out < 3; k++)
            @(posedge i_clk);
        if (k == 400)
            give_up();
        chk(unlock, 1'b1, "lock release");
        chk(n_in, 0, "recal inward");
        outer <= 1'b1;
        wait_oe(0, 1'b1, 2000);
        chk(stat_oe, 4'h7, "recal status");
        rchk(seek_pkg::OFS_STAT, 32'h27, "stat reg");
        rchk(seek_pkg::OFS_POS, 32'h0, "pos recal");
        $display("test recal done");
        host.select(4'h2);
        repeat (3) @(posedge i_clk);
        #1;
        chk(stat_oe, 4'h0, "unselected oe");
        host.step(2, 1'b0);
        rchk(seek_pkg::OFS_PEND, 32'h0, "unselected pulse");
        bus(1'b1, seek_pkg::OFS_CTRL, 32'h1);
        repeat (3) @(posedge i_clk);
        #1;
        chk(stat_oe, 4'h7, "selected oe");
        wsz = 3'h0;
        bus(1'b1, seek_pkg::OFS_CTRL, 32'h0);
        wsz = 3'h2;
        rchk(seek_pkg::OFS_CTRL, 32'h1, "byte write ignored");
        $display("test select done");
        @(posedge i_clk);
        outer <= 1'b0;
        host.step(0, 1'b0);
        host.press();
        rchk(seek_pkg::OFS_PEND, 32'h0, "leading edge");
        host.lift();
        rchk(seek_pkg::OFS_PEND, 32'h1, "trailing edge");
        wait_oe(1, 1'b0, 2000);
        wait_oe(1, 1'b1, 6000);
        seek(4, 1'b0, 5);
        seek(5, 1'b1, 0);
        for (k = 0; k < 16; k += 5)
        begin
            host.head(k[3:0]);
            repeat (2) @(posedge i_clk);
            #1;
            chk(head_sel, k[3:0], "head");
        end
        host.record(1'b1);
        repeat (3) @(posedge i_clk);
        #1;
        chk(wr_en, 1'b1, "write on");
        @(posedge i_clk);
        fault <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk(wr_en, 1'b0, "write blocked");
        chk(stat_oe[3], 1'b1, "fault flag");
        host.record(1'b0);
        host.step(1, 1'b0);
        rchk(seek_pkg::OFS_PEND, 32'h0, "step blocked");
        $display("test fault done");
        rchk(32'h10, 32'h0, "unmapped");
        chk(hresp, 1'b0, "response okay");
        chk(stat_n, 4'h0, "status pin level");
        finish_test();
    end
endmodule : seek_step_drive_interface_tb
